/* logic/watchdog_soft_reset_ctrl.sv */
// watchdog and software-reset controller with apb register access
`timescale 1ns/1ps
// How it works
// R1 - bytes 5a then a5 on the sequence port issue a software reset
// R2 - software reset works whether or not the counter runs
// R3 - a good software reset sets the soft reset flag until software clears it
// R4 - any other sequence resets at once and sets both flags
// R5 - bytes 1e then e1 enable the watchdog counter
// R6 - software feeds with 1e then e1 before time-out; feeding restarts the count
// R7 - control bit 0 reads 1 while the counter is enabled
// R8 - period select in bits 7..5: 16k cycles at zero, 2048k at all ones
// R9 - idle freeze bit 4 holds the count while idle, else it keeps counting
// R10 - each select step doubles the period: 2^(select+14) cycles
// R11 - time-out without feeding emits an internal reset pulse
// R12 - system reset disables the watchdog; it never runs in power-down
// R13 - a register write between sequence bytes breaks the sequence
// R14 - time-out sets the overflow flag; flags survive and clear only by writing 0 or by system reset
// R15 - internal state tracks the first byte so the second can be checked
module watchdog_soft_reset_ctrl (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        idle_mode,
    input  wire logic        power_down,
    output logic             cpu_reset_pulse,
    output logic             irq
);
    // ------------------------------------------------------------
    // mode pins from outside the clock domain
    // ------------------------------------------------------------
    logic [1:0] idle_sync_q;
    logic [1:0] idle_sync_d;
    logic [1:0] pd_sync_q;
    logic [1:0] pd_sync_d;

    // two stages each; only the second stage feeds the counter logic
    always_comb begin
        idle_sync_d = {idle_sync_q[0], idle_mode};
        pd_sync_d   = {pd_sync_q[0], power_down};
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            idle_sync_q <= 2'b00;
            pd_sync_q   <= 2'b00;
        end else begin
            idle_sync_q <= idle_sync_d;
            pd_sync_q   <= pd_sync_d;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic wr_seq;
    logic wr_ctrl;
    logic wr_clr;
    logic wr_ien;

    assign access  = psel & penable & pready;
    assign wr_en   = access & pwrite;
    assign rd_en   = access & ~pwrite;
    assign hit     = (paddr == watchdog_pkg::CTRL_ADDR)     ||
                     (paddr == watchdog_pkg::SEQ_ADDR)      ||
                     (paddr == watchdog_pkg::IRQ_STAT_ADDR) ||
                     (paddr == watchdog_pkg::IRQ_CLR_ADDR)  ||
                     (paddr == watchdog_pkg::IRQ_EN_ADDR)   ||
                     (paddr == watchdog_pkg::CTRL_IN_ADDR)  ||
                     (paddr == watchdog_pkg::CTRL_OUT_ADDR) ||
                     (paddr == watchdog_pkg::COUNT_ADDR);
    assign wr_seq  = wr_en & (paddr == watchdog_pkg::SEQ_ADDR);
    assign wr_ctrl = wr_en & (paddr == watchdog_pkg::CTRL_ADDR);
    assign wr_clr  = wr_en & (paddr == watchdog_pkg::IRQ_CLR_ADDR);
    assign wr_ien  = wr_en & (paddr == watchdog_pkg::IRQ_EN_ADDR);

    // ------------------------------------------------------------
    // sequence checker
    // ------------------------------------------------------------
    seq_if sq ();

    assign sq.wr       = wr_seq;
    assign sq.data     = pwdata[7:0];
    assign sq.other_wr = wr_en & ~wr_seq; // R13

    seq_checker u_seq (
        .core_clk (core_clk),
        .reset    (reset),
        .sq       (sq)
    );

    // ------------------------------------------------------------
    // control register and counter
    // ------------------------------------------------------------
    logic [7:0]                    ctrl_q;
    logic [7:0]                    ctrl_d;
    logic [watchdog_pkg::CNT_W-1:0] count_q;
    logic [watchdog_pkg::CNT_W-1:0] count_d;
    logic [watchdog_pkg::CNT_W-1:0] limit;
    logic [2:0]                    sel;
    logic [4:0]                    period_exp;
    logic                          running;
    logic                          timeout;
    logic                          fire;

    assign sel     = ctrl_q[watchdog_pkg::PS_MSB:watchdog_pkg::PS_LSB];
    // period is 2^(sel+14); terminal count is one less. the exponent is five bits
    // wide because sel plus 14 does not fit in the three bits of sel
    assign period_exp = 5'(sel) + 5'(watchdog_pkg::BASE_EXP);
    assign limit   = watchdog_pkg::CNT_W'(({{(watchdog_pkg::CNT_W-1){1'b0}}, 1'b1}
                     << period_exp) - 1'b1); // R8 R10
    // frozen in power-down, and in idle only when asked to
    assign running = ctrl_q[watchdog_pkg::EN_BIT] & ~pd_sync_q[1] &
                     ~(idle_sync_q[1] & ctrl_q[watchdog_pkg::IDLE_BIT]); // R9 R12
    assign timeout = running & (count_q == limit) & ~sq.feed; // R11
    assign fire    = timeout | sq.soft_rst | sq.bad_seq; // R2

    always_comb begin
        ctrl_d  = ctrl_q;
        count_d = count_q;
        if (wr_ctrl) begin
            // flags are write-zero-to-clear only; a one written leaves them
            ctrl_d[watchdog_pkg::PS_MSB:watchdog_pkg::PS_LSB] =
                pwdata[watchdog_pkg::PS_MSB:watchdog_pkg::PS_LSB]; // R8
            ctrl_d[watchdog_pkg::IDLE_BIT] = pwdata[watchdog_pkg::IDLE_BIT]; // R9
            ctrl_d[watchdog_pkg::SWR_BIT]  = ctrl_q[watchdog_pkg::SWR_BIT] &
                                             pwdata[watchdog_pkg::SWR_BIT]; // R14
            ctrl_d[watchdog_pkg::OVF_BIT]  = ctrl_q[watchdog_pkg::OVF_BIT] &
                                             pwdata[watchdog_pkg::OVF_BIT]; // R14
        end
        if (running) begin
            count_d = count_q + 1'b1;
        end
        if (sq.feed) begin
            ctrl_d[watchdog_pkg::EN_BIT] = 1'b1; // R5 R7
            count_d = '0;
        end
        // a reset event disables the counter; set wins over a same-cycle clear
        if (fire) begin
            ctrl_d[watchdog_pkg::EN_BIT] = 1'b0;
            count_d = '0;
        end
        if (sq.soft_rst | sq.bad_seq) begin
            ctrl_d[watchdog_pkg::SWR_BIT] = 1'b1; // R3 R4
        end
        if (sq.bad_seq | timeout) begin
            ctrl_d[watchdog_pkg::OVF_BIT] = 1'b1; // R4 R14
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q  <= watchdog_pkg::CTRL_RESET; // R12
            count_q <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // internal reset pulse
    // ------------------------------------------------------------
    logic [3:0] pulse_q;
    logic [3:0] pulse_d;
    logic       cpu_reset_pulse_d;

    always_comb begin
        pulse_d = pulse_q;
        if (fire) begin
            pulse_d = watchdog_pkg::RST_PULSE_LEN; // R11
        end else if (pulse_q != 4'h0) begin
            pulse_d = pulse_q - 4'h1;
        end
        cpu_reset_pulse_d = (pulse_d != 4'h0);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pulse_q         <= 4'h0;
            cpu_reset_pulse <= 1'b0;
        end else begin
            pulse_q         <= pulse_d;
            cpu_reset_pulse <= cpu_reset_pulse_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, enable and clear
    // ------------------------------------------------------------
    logic [watchdog_pkg::IRQ_W-1:0] stat_q;
    logic [watchdog_pkg::IRQ_W-1:0] stat_d;
    logic [watchdog_pkg::IRQ_W-1:0] ien_q;
    logic [watchdog_pkg::IRQ_W-1:0] ien_d;
    logic [watchdog_pkg::IRQ_W-1:0] events;
    logic                           irq_d;

    assign events = {sq.bad_seq, sq.soft_rst, timeout};

    always_comb begin
        stat_d = stat_q;
        ien_d  = ien_q;
        if (wr_clr) begin
            stat_d = stat_q & ~pwdata[watchdog_pkg::IRQ_W-1:0];
        end
        if (wr_ien) begin
            ien_d = pwdata[watchdog_pkg::IRQ_W-1:0];
        end
        // an event in the cycle of its clear keeps the bit set
        stat_d = stat_d | events;
        irq_d  = |(stat_d & ien_d);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stat_q <= '0;
            ien_q  <= '0;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            ien_q  <= ien_d;
            irq    <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // apb answer: no wait state, reads registered
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            watchdog_pkg::CTRL_ADDR:     rdata_d = {24'h000000, ctrl_q};
            watchdog_pkg::IRQ_STAT_ADDR: rdata_d = {29'h0, stat_q};
            watchdog_pkg::IRQ_EN_ADDR:   rdata_d = {29'h0, ien_q};
            watchdog_pkg::COUNT_ADDR:    rdata_d = {10'h000, count_q};
            default:                     rdata_d = 32'h0000_0000;
        endcase
    end

    // the answer is prepared in the setup cycle so that it stands in the access cycle;
    // read data is held between reads
    always_comb begin
        pready_d  = psel & ~penable;
        pslverr_d = psel & ~penable & ~hit;
        prdata_d  = prdata;
        if (psel & ~penable & ~pwrite) begin
            prdata_d = rdata_d;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= pready_d;
            pslverr <= pslverr_d;
            prdata  <= prdata_d;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

/* logic/watchdog_pkg.sv */
// shared constants of the watchdog and software-reset controller
package watchdog_pkg;
    // ------------------------------------------------------------
    // register map (apb byte addresses; control register at 0xa7 is an index)
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_INDEX      = 8'ha7;
    localparam logic [11:0] CTRL_ADDR       = 12'h29c;
    localparam logic [11:0] SEQ_ADDR        = 12'h2a0;
    localparam logic [11:0] IRQ_STAT_ADDR   = 12'h2a4;
    localparam logic [11:0] IRQ_CLR_ADDR    = 12'h2a8;
    localparam logic [11:0] IRQ_EN_ADDR     = 12'h2ac;
    localparam logic [11:0] CTRL_IN_ADDR    = 12'h2b0;
    localparam logic [11:0] CTRL_OUT_ADDR   = 12'h2b4;
    localparam logic [11:0] COUNT_ADDR      = 12'h2b8;
    localparam int          ADDR_W          = 12;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          EN_BIT          = 0;
    localparam int          OVF_BIT         = 1;
    localparam int          SWR_BIT         = 2;
    localparam int          IDLE_BIT        = 4;
    localparam int          PS_LSB          = 5;
    localparam int          PS_MSB          = 7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    // writable by software: period select, idle freeze, the two flags (0 clears)
    localparam logic [7:0]  CTRL_WMASK      = 8'hf6;

    // ------------------------------------------------------------
    // sequence bytes
    // ------------------------------------------------------------
    localparam logic [7:0]  FEED_FIRST      = 8'h1e;
    localparam logic [7:0]  FEED_SECOND     = 8'he1;
    localparam logic [7:0]  SWR_FIRST       = 8'h5a;
    localparam logic [7:0]  SWR_SECOND      = 8'ha5;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          BASE_EXP        = 14;
    localparam int          CNT_W           = 22;
    localparam int          RST_PULSE_NS    = 200;
    localparam int          CLK_MHZ         = 20;
    localparam int          RST_PULSE_CYC   = (RST_PULSE_NS * CLK_MHZ) / 1000;
    localparam logic [3:0]  RST_PULSE_LEN   = 4'(RST_PULSE_CYC);

    // interrupt status bits
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_TIMEOUT     = 0;
    localparam int          IRQ_SWRESET     = 1;
    localparam int          IRQ_BADSEQ      = 2;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_HALF = 2'b10
    } seq_state_t;
endpackage

/* logic/seq_if.sv */
// carrier between the sequence checker and the controller top
`timescale 1ns/1ps
interface seq_if;
    logic       wr;
    logic [7:0] data;
    logic       other_wr;
    logic       feed;
    logic       soft_rst;
    logic       bad_seq;
    logic       pending;
    modport checker_side (input wr, data, other_wr, output feed, soft_rst, bad_seq, pending);
    modport ctrl_side    (output wr, data, other_wr, input feed, soft_rst, bad_seq, pending);
endinterface

/* logic/seq_checker.sv */
// two-byte sequence checker for the watchdog sequence port
`timescale 1ns/1ps
module seq_checker (
    input  wire logic      core_clk,
    input  wire logic      reset,
    seq_if.checker_side    sq
);
    watchdog_pkg::seq_state_t state_q;
    watchdog_pkg::seq_state_t state_d;
    logic [7:0]               first_q;
    logic [7:0]               first_d;

    always_comb begin
        state_d     = state_q;
        first_d     = first_q;
        sq.feed     = 1'b0;
        sq.soft_rst = 1'b0;
        sq.bad_seq  = 1'b0;
        case (state_q)
            watchdog_pkg::SEQ_IDLE: begin
                if (sq.wr) begin
                    // remember the opening byte to check its partner
                    if (sq.data == watchdog_pkg::FEED_FIRST ||
                        sq.data == watchdog_pkg::SWR_FIRST) begin // R15
                        state_d = watchdog_pkg::SEQ_HALF;
                        first_d = sq.data;
                    end else begin
                        sq.bad_seq = 1'b1; // R4
                    end
                end
            end
            watchdog_pkg::SEQ_HALF: begin
                if (sq.other_wr) begin
                    // any other register write breaks the sequence
                    sq.bad_seq = 1'b1; // R13
                    state_d    = watchdog_pkg::SEQ_IDLE;
                end else if (sq.wr) begin
                    state_d = watchdog_pkg::SEQ_IDLE;
                    if (first_q == watchdog_pkg::FEED_FIRST &&
                        sq.data == watchdog_pkg::FEED_SECOND) begin
                        sq.feed = 1'b1; // R5
                    end else if (first_q == watchdog_pkg::SWR_FIRST &&
                                 sq.data == watchdog_pkg::SWR_SECOND) begin
                        sq.soft_rst = 1'b1; // R1
                    end else begin
                        sq.bad_seq = 1'b1; // R4
                    end
                end
            end
            default: begin
                state_d = watchdog_pkg::SEQ_IDLE;
            end
        endcase
    end

    assign sq.pending = (state_q == watchdog_pkg::SEQ_HALF);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= watchdog_pkg::SEQ_IDLE;
            first_q <= 8'h00;
        end else begin
            state_q <= state_d;
            first_q <= first_d;
        end
    end
endmodule

/* bench/watchdog_asserts.sv */
// concurrent checks on the ports of the watchdog controller
`timescale 1ns/1ps
module watchdog_asserts (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    input  wire logic        cpu_reset_pulse,
    input  wire logic        irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    logic seq_wr;
    assign seq_wr = psel && penable && pready && pwrite && paddr == watchdog_pkg::SEQ_ADDR;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    ready_after_setup_a: assert property (setup_s |=> access_s)
        else $error("no answer in the access cycle");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    err_with_ready_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error response malformed");
    ctrl_layout_a: assert property (access_s ##0 (!pwrite && paddr == watchdog_pkg::CTRL_ADDR)
        |-> prdata[31:8] == 24'h0 && !prdata[3]) else $error("control read shows stray bits");
    pulse_width_a: assert property ($rose(cpu_reset_pulse) |-> cpu_reset_pulse[*4] ##1 !cpu_reset_pulse)
        else $error("reset pulse width wrong");
    bad_byte_reset_a: assert property (seq_wr && !(pwdata[7:0] inside {8'h1e, 8'he1, 8'h5a, 8'ha5})
        |-> ##[1:4] $rose(cpu_reset_pulse)) else $error("bad byte gave no reset");
    irq_mask_off_a: assert property (access_s ##0 (pwrite && paddr == watchdog_pkg::IRQ_EN_ADDR
        && pwdata[2:0] == 3'h0) |-> ##2 !irq) else $error("masked interrupt still high");
endmodule
bind watchdog_soft_reset_ctrl watchdog_asserts u_asserts (.core_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .cpu_reset_pulse, .irq);

/* bench/watchdog_soft_reset_ctrl_bench.sv */
// self-checking bench for the watchdog and software-reset controller
`timescale 1ns/1ps
module watchdog_soft_reset_ctrl_bench;
    localparam logic [11:0] CTRL = watchdog_pkg::CTRL_ADDR;
    localparam logic [11:0] SEQ  = watchdog_pkg::SEQ_ADDR;
    localparam logic [11:0] CNT  = watchdog_pkg::COUNT_ADDR;
    logic        core_clk, reset, psel, penable, pwrite, idle_mode, power_down;
    logic        pready, pslverr, cpu_reset_pulse, irq, err_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] rnd;
    int          errors, samples_checked, t0, p0;
    int          cyc    = 0;
    int          pulses = 0;

    watchdog_soft_reset_ctrl dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .idle_mode, .power_down, .cpu_reset_pulse, .irq);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc    <= cyc + 1;
        pulses <= pulses + int'($rose(cpu_reset_pulse));
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            conclude();
        end
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd_q, exp);
    endtask
    task automatic feed;
        apb(1'b1, SEQ, 32'h1e);
        apb(1'b1, SEQ, 32'he1);
    endtask
    // clears the flags, sends two bytes, then checks pulses and control
    task automatic seq2(input logic [7:0] b1, input logic [7:0] b2, input logic [31:0] exp,
                        input int np);
        apb(1'b1, CTRL, 32'h0);
        p0 = pulses;
        apb(1'b1, SEQ, {24'h0, b1});
        apb(1'b1, SEQ, {24'h0, b2});
        repeat (8) @(posedge core_clk);
        check(32'(pulses - p0), 32'(np));
        rd(CTRL, exp);
    endtask
    task automatic count_twice(input logic same);
        logic [31:0] a;
        repeat (4) @(posedge core_clk);
        apb(1'b0, CNT, 32'h0);
        a = rd_q;
        repeat (20) @(posedge core_clk);
        apb(1'b0, CNT, 32'h0);
        check({31'h0, a === rd_q}, {31'h0, same});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        samples_checked = 0;
        {reset, psel, penable, pwrite, idle_mode, power_down} = 6'h20;
        paddr = 12'h0;
        pwdata = 32'h0;
        rnd = 16'haa2a;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        rd(CTRL, 32'h0);
        rd(12'h004, 32'h0);
        check({31'h0, err_q}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, CTRL, {16'h0, rnd});
            rd(CTRL, {24'h0, rnd[7:4], 4'h0});
        end
        apb(1'b1, watchdog_pkg::IRQ_EN_ADDR, 32'h7);
        seq2(8'h1e, 8'he1, 32'h1, 0);
        apb(1'b1, CTRL, 32'h10);
        idle_mode <= 1'b1;
        count_twice(1'b1);
        apb(1'b1, CTRL, 32'h0);
        count_twice(1'b0);
        idle_mode  <= 1'b0;
        power_down <= 1'b1;
        count_twice(1'b1);
        power_down <= 1'b0;
        // the second feed must restart the count, so the time-out is timed from it
        feed();
        repeat (5000) @(posedge core_clk);
        feed();
        t0 = cyc;
        p0 = pulses;
        for (int n = 0; n < 20000 && pulses == p0; n++)
            @(posedge core_clk);
        check({31'h0, (cyc - t0) inside {[16380:16395]}}, 32'h1);
        repeat (6) @(posedge core_clk);
        rd(CTRL, 32'h2);
        rd(watchdog_pkg::IRQ_STAT_ADDR, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, watchdog_pkg::IRQ_CLR_ADDR, 32'h7);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        seq2(8'h5a, 8'ha5, 32'h4, 1);
        apb(1'b1, watchdog_pkg::IRQ_EN_ADDR, 32'h0);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, watchdog_pkg::IRQ_EN_ADDR, 32'h7);
        apb(1'b1, CTRL, 32'h0);
        feed();
        seq2(8'h5a, 8'ha5, 32'h4, 1);
        seq2(8'h1e, 8'ha5, 32'h6, 1);
        seq2(8'h5a, 8'he1, 32'h6, 1);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            seq2(8'h1e, (rnd[7:0] == 8'he1) ? 8'h00 : rnd[7:0], 32'h6, 1);
        end
        apb(1'b1, CTRL, 32'h0);
        p0 = pulses;
        apb(1'b1, SEQ, 32'h5a);
        apb(1'b1, watchdog_pkg::IRQ_EN_ADDR, 32'h7);
        repeat (8) @(posedge core_clk);
        check(32'(pulses - p0), 32'h1);
        rd(CTRL, 32'h6);
        apb(1'b1, CTRL, 32'h0);
        apb(1'b1, SEQ, 32'h1e);
        apb(1'b0, CTRL, 32'h0);
        apb(1'b1, SEQ, 32'he1);
        rd(CTRL, 32'h1);
        // select one doubles the period; the pulse counter shows it two edges late
        apb(1'b1, CTRL, 32'h20);
        feed();
        t0 = cyc;
        p0 = pulses;
        for (int n = 0; n < 40000 && pulses == p0; n++)
            @(posedge core_clk);
        check(32'(cyc - t0), (32'h1 << (watchdog_pkg::BASE_EXP + 1)) + 32'h2);
        conclude();
    end
endmodule
